// [src/nv_pkg.sv]
// Package for the nonvolatile data memory controller.
// Assumes a single 50 MHz core clock and an APB register bus.
package nv_pkg;
    // --------------------------------------------------------------
    // Register offsets (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR_LO = 8'h00;   // Low address byte
    localparam logic [7:0] OFF_ADDR_HI = 8'h04;   // High address bits
    localparam logic [7:0] OFF_DATA    = 8'h08;   // Data byte
    localparam logic [7:0] OFF_CTRL    = 8'h0C;   // Control byte
    localparam logic [7:0] OFF_STAT    = 8'h10;   // Done flag and busy

    // --------------------------------------------------------------
    // Control field positions
    // --------------------------------------------------------------
    localparam int CB_TSEL = 7;                   // Timing select
    localparam int CB_ERASE_ENABLE = 6;                   // Erase enable
    localparam int CB_ER   = 5;                   // Erase start
    localparam int CB_MODE = 4;                   // Page mode
    localparam int CB_WRITE_ENABLE_BIT = 3;                   // Write enable
    localparam int CB_WR   = 2;                   // Write start
    localparam int CB_READ_ENABLE_BIT = 1;                   // Read enable
    localparam int CB_RD   = 0;                   // Read start
    localparam int SB_DONE = 0;                   // Done flag position
    localparam int SB_BUSY = 1;                   // Busy position

    // --------------------------------------------------------------
    // Reset values and sizes
    // --------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;     // Data and control reset
    localparam int         MEM_BYTES = 1024;      // Array size
    localparam int         PAGE_SZ   = 16;        // Page buffer bytes
    localparam logic [3:0] PAGE_END  = 4'hF;      // Last slot in page

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;            // 50 MHz
    localparam int ERASE0_NS     = 3_200_000;     // Erase, select 0
    localparam int WRITE0_NS     = 2_200_000;     // Write, select 0
    localparam int ERASE1_NS     = 3_700_000;     // Erase, select 1
    localparam int WRITE1_NS     = 3_000_000;     // Write, select 1
    localparam int ERASE0_CYC    = ERASE0_NS / CLK_PERIOD_NS;
    localparam int WRITE0_CYC    = WRITE0_NS / CLK_PERIOD_NS;
    localparam int ERASE1_CYC    = ERASE1_NS / CLK_PERIOD_NS;
    localparam int WRITE1_CYC    = WRITE1_NS / CLK_PERIOD_NS;
    localparam int READ_CYC      = 2;             // Read latency
    localparam int TMR_W         = 18;            // Timer width

    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_PROG, ST_COMMIT, ST_CLEAN
    } nv_state_t;
endpackage

// [src/nv_prog_timer.sv]
// Program cycle timer for the nonvolatile controller.
// Assumes a start pulse with a load value; gives a one-cycle done pulse.
`timescale 1ns/10ps
module nv_prog_timer (
    input  wire logic                     clk,     // Core clock
    input  wire logic                     rst,     // Sync reset, high
    input  wire logic                     start,   // Load and run
    input  wire logic [nv_pkg::TMR_W-1:0] load,    // Cycles to run
    output logic                          done     // End pulse
);
    import nv_pkg::*;

    logic [TMR_W-1:0] cnt_q, cnt_d;              // Remaining cycles
    logic             run_q, run_d;              // Counting
    logic             done_q, done_d;            // Registered pulse

    // ----------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------
    always_comb begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (start) begin
            // Restart with the chosen duration
            cnt_d = load;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= TMR_W'(1)) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - TMR_W'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule

// [src/nv_ctrl.sv]
// Nonvolatile data memory controller with APB register access.
// Assumes a single core clock, synchronous reset, and a stable sub clock.
`timescale 1ns/10ps

module nv_ctrl #(
    parameter int ERASE0_CYCLES = nv_pkg::ERASE0_CYC,   // Erase cycles, select 0
    parameter int WRITE0_CYCLES = nv_pkg::WRITE0_CYC,   // Write cycles, select 0
    parameter int ERASE1_CYCLES = nv_pkg::ERASE1_CYC,   // Erase cycles, select 1
    parameter int WRITE1_CYCLES = nv_pkg::WRITE1_CYC    // Write cycles, select 1
) (
    input  wire logic        CORE_CLK,      // Core clock
    input  wire logic        SYS_RST,       // Sync reset, high
    input  wire logic        PSEL,          // APB select
    input  wire logic        PENABLE,       // APB access phase
    input  wire logic        PWRITE,        // APB direction
    input  wire logic [7:0]  PADDR,         // APB byte address
    input  wire logic [31:0] PWDATA,        // APB write data
    output logic      [31:0] PRDATA,        // APB read data
    output logic             PREADY,        // APB ready
    output logic             PSLVERR,       // Unmapped address
    output logic             NV_DONE,       // Done flag level
    output logic             NV_BUSY        // Operation running
);
    import nv_pkg::*;

    // --------------------------------------------------------------
    // Storage and state
    // --------------------------------------------------------------
    logic [7:0]       mem [MEM_BYTES];        // Data array
    logic [7:0]       buf_q [PAGE_SZ];        // Page buffer
    logic [7:0]       buf_d [PAGE_SZ];
    logic [15:0]      tag_q, tag_d;           // Slot tags
    logic [7:0]       alo_q, alo_d;           // Low address
    logic [1:0]       ahi_q, ahi_d;           // High address
    logic [7:0]       data_q, data_d;         // Data register
    logic [7:0]       ctrl_q, ctrl_d;         // Control register
    logic             done_q, done_d;         // Completion flag
    nv_state_t        st_q, st_d;             // Sequencer state
    logic [3:0]       cnt_q, cnt_d;           // Read wait / slot index
    logic             erop_q, erop_d;         // Running op is erase
    logic             arm_e_q, arm_e_d;       // Erase enable just set
    logic             arm_w_q, arm_w_d;       // Write enable just set
    logic             rdy_q, rdy_d;           // APB ready
    logic [31:0]      prd_q, prd_d;           // APB read data
    logic             err_q, err_d;           // APB error
    logic             tmr_go;                 // Timer start pulse
    logic [TMR_W-1:0] tmr_load;               // Timer load value
    logic             tmr_done;               // Timer end pulse
    logic             mem_we;                 // Array write enable
    logic [9:0]       mem_wa;                 // Array write address
    logic [7:0]       mem_wd;                 // Array write data
    logic             acc, wacc;              // Completing access
    logic             mapped;                 // Address decodes
    logic [7:0]       wb, nb;                 // Write byte, new control
    logic [9:0]       addr;                   // Current address

    // Saturating page offset increment
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        return (v == PAGE_END) ? PAGE_END : v + 4'h1;
    endfunction

    // Cycle count as timer load value
    function automatic logic [TMR_W-1:0] cyc(input int n);
        return n[TMR_W-1:0];
    endfunction

    assign addr   = {ahi_q, alo_q};
    assign acc    = PSEL & PENABLE & rdy_q;
    assign wacc   = acc & PWRITE;
    assign wb     = PWDATA[7:0];
    assign mapped = (PADDR == OFF_ADDR_LO) || (PADDR == OFF_ADDR_HI) ||
                    (PADDR == OFF_DATA) || (PADDR == OFF_CTRL) ||
                    (PADDR == OFF_STAT);

    // --------------------------------------------------------------
    // Program timer
    // --------------------------------------------------------------
    nv_prog_timer u_tmr (
        .clk   (CORE_CLK),
        .rst   (SYS_RST),
        .start (tmr_go),
        .load  (tmr_load),
        .done  (tmr_done)
    );

    // --------------------------------------------------------------
    // APB slave: one wait state, then ready with data
    // --------------------------------------------------------------
    always_comb begin
        rdy_d = PSEL & PENABLE & ~rdy_q;
        prd_d = prd_q;
        err_d = 1'b0;
        if (rdy_d) begin
            err_d = ~mapped;
            unique case (PADDR)
                OFF_ADDR_LO: prd_d = {24'h00_0000, alo_q};
                OFF_ADDR_HI: prd_d = {30'h0000_0000, ahi_q};
                OFF_DATA:    prd_d = {24'h00_0000, data_q};
                OFF_CTRL:    prd_d = {24'h00_0000, ctrl_q};
                OFF_STAT:    prd_d = {30'h0000_0000, st_q != ST_IDLE, done_q};
                default:     prd_d = 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Register file and sequencer next values
    // --------------------------------------------------------------
    always_comb begin
        buf_d    = buf_q;
        tag_d    = tag_q;
        alo_d    = alo_q;
        ahi_d    = ahi_q;
        data_d   = data_q;
        ctrl_d   = ctrl_q;
        done_d   = done_q;
        st_d     = st_q;
        cnt_d    = cnt_q;
        erop_d   = erop_q;
        arm_e_d  = arm_e_q;
        arm_w_d  = arm_w_q;
        tmr_go   = 1'b0;
        tmr_load = '0;
        mem_we   = 1'b0;
        mem_wa   = addr;
        mem_wd   = 8'h00;
        nb       = ctrl_q;

        // Software register writes; the done clear at any time, all others only while idle
        if (acc) begin
            arm_e_d = 1'b0;
            arm_w_d = 1'b0;
        end
        if (wacc && PADDR == OFF_STAT && wb[SB_DONE]) begin
            done_d = 1'b0;                      // Write one clears
        end
        if (wacc && st_q == ST_IDLE) begin
            unique case (PADDR)
                OFF_ADDR_LO: alo_d = wb;
                OFF_ADDR_HI: ahi_d = wb[1:0];
                OFF_DATA: begin
                    data_d = wb;
                    // Page mode: tag slot and advance
                    if (ctrl_q[CB_MODE] &&
                        !(alo_q[3:0] == PAGE_END && tag_q[PAGE_END])) begin
                        buf_d[alo_q[3:0]] = wb;
                        tag_d[alo_q[3:0]] = 1'b1;
                        alo_d[3:0]        = sat_inc(alo_q[3:0]);
                    end
                end
                OFF_CTRL: begin
                    nb = wb;
                    // Erase and write start only with enable already set and just armed; read needs its enable set and no erase or write start
                    nb[CB_ER] = wb[CB_ER] & ctrl_q[CB_ERASE_ENABLE] & arm_e_q;
                    nb[CB_WR] = wb[CB_WR] & ~nb[CB_ER] & ctrl_q[CB_WRITE_ENABLE_BIT] &
                                arm_w_q;
                    nb[CB_RD] = wb[CB_RD] & ~nb[CB_ER] & ~nb[CB_WR] &
                                ctrl_q[CB_READ_ENABLE_BIT];
                    arm_e_d   = wb[CB_ERASE_ENABLE] & ~ctrl_q[CB_ERASE_ENABLE];
                    arm_w_d   = wb[CB_WRITE_ENABLE_BIT] & ~ctrl_q[CB_WRITE_ENABLE_BIT];
                    ctrl_d    = nb;
                    if (nb[CB_ER] || nb[CB_WR]) begin
                        erop_d   = nb[CB_ER];
                        tmr_go   = 1'b1;
                        st_d     = ST_PROG;
                        // Duration from kind and timing select
                        if (nb[CB_ER]) begin
                            tmr_load = ctrl_q[CB_TSEL] ? cyc(ERASE1_CYCLES)
                                                       : cyc(ERASE0_CYCLES);
                        end else begin
                            tmr_load = ctrl_q[CB_TSEL] ? cyc(WRITE1_CYCLES)
                                                       : cyc(WRITE0_CYCLES);
                        end
                    end else if (nb[CB_RD]) begin
                        cnt_d = 4'h0;
                        st_d  = ST_READ;
                    end
                    // Enable fall empties the page buffer
                    if ((ctrl_q[CB_ERASE_ENABLE] && !nb[CB_ERASE_ENABLE]) ||
                        (ctrl_q[CB_WRITE_ENABLE_BIT] && !nb[CB_WRITE_ENABLE_BIT])) begin
                        tag_d = '0;
                        for (int i = 0; i < PAGE_SZ; i++) begin
                            buf_d[i] = 8'h00;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Sequencer
        unique case (st_q)
            ST_IDLE: ;
            ST_READ: begin
                // Fixed latency fetch
                if (cnt_q == 4'(READ_CYC - 1)) begin
                    data_d        = mem[addr];
                    ctrl_d[CB_RD] = 1'b0;
                    if (ctrl_q[CB_MODE]) begin
                        alo_d[3:0] = sat_inc(alo_q[3:0]);
                    end
                    st_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            ST_PROG: begin
                // Duration held by the program timer
                if (tmr_done) begin
                    cnt_d = 4'h0;
                    st_d  = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                // Byte mode: single location; page mode: tagged slots
                if (!ctrl_q[CB_MODE]) begin
                    mem_we = 1'b1;
                    mem_wd = erop_q ? 8'h00 : data_q;
                end else begin
                    mem_wa = {ahi_q, alo_q[7:4], cnt_q};
                    mem_we = tag_q[cnt_q];
                    mem_wd = erop_q ? 8'h00 : buf_q[cnt_q];
                end
                if (!ctrl_q[CB_MODE] || cnt_q == PAGE_END) begin
                    ctrl_d[CB_ER] = 1'b0;
                    ctrl_d[CB_WR] = 1'b0;
                    st_d          = ST_CLEAN;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            ST_CLEAN: begin
                // Enable falls after the start bit; buffer empties
                if (erop_q) begin
                    ctrl_d[CB_ERASE_ENABLE] = 1'b0;
                end else begin
                    ctrl_d[CB_WRITE_ENABLE_BIT] = 1'b0;
                end
                tag_d = '0;
                for (int i = 0; i < PAGE_SZ; i++) begin
                    buf_d[i] = 8'h00;
                end
                done_d = 1'b1;                // Set wins over clear
                st_d   = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < PAGE_SZ; i++) begin
                buf_q[i] <= 8'h00;
            end
            tag_q   <= '0;
            alo_q   <= RST_BYTE;
            ahi_q   <= 2'h0;
            data_q  <= RST_BYTE;
            ctrl_q  <= RST_BYTE;
            done_q  <= 1'b0;
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            erop_q  <= 1'b0;
            arm_e_q <= 1'b0;
            arm_w_q <= 1'b0;
            rdy_q   <= 1'b0;
            prd_q   <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            buf_q   <= buf_d;
            tag_q   <= tag_d;
            alo_q   <= alo_d;
            ahi_q   <= ahi_d;
            data_q  <= data_d;
            ctrl_q  <= ctrl_d;
            done_q  <= done_d;
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            erop_q  <= erop_d;
            arm_e_q <= arm_e_d;
            arm_w_q <= arm_w_d;
            rdy_q   <= rdy_d;
            prd_q   <= prd_d;
            err_q   <= err_d;
        end
    end

    // Array write port, no reset on contents
    always_ff @(posedge CORE_CLK) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Busy flag register
    logic busy_q;                             // Running operation
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (st_d != ST_IDLE);
        end
    end

    // --------------------------------------------------------------
    // Outputs, all from flip-flops
    // --------------------------------------------------------------
    assign PRDATA  = prd_q;
    assign PREADY  = rdy_q;
    assign PSLVERR = err_q;
    assign NV_DONE = done_q;
    assign NV_BUSY = busy_q;
endmodule

// [testbench/nv_ctrl_monitor.sv]
// Checker for the nonvolatile memory controller.
// Assumes it is bound to nv_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module nv_ctrl_monitor #(
    parameter int ERASE0_CYCLES = 20,         // Erase cycles, select 0
    parameter int WRITE0_CYCLES = 15,         // Write cycles, select 0
    parameter int ERASE1_CYCLES = 25,         // Erase cycles, select 1
    parameter int WRITE1_CYCLES = 18          // Write cycles, select 1
) (
    input wire logic        CORE_CLK,         // Core clock
    input wire logic        SYS_RST,          // Sync reset, high
    input wire logic        PSEL,             // APB select
    input wire logic        PENABLE,          // APB access phase
    input wire logic        PWRITE,           // APB direction
    input wire logic [7:0]  PADDR,            // APB address
    input wire logic [31:0] PRDATA,           // APB read data
    input wire logic        PREADY,           // APB ready
    input wire logic        PSLVERR,          // APB error
    input wire logic        NV_DONE,          // Done flag
    input wire logic        NV_BUSY           // Busy level
);
    import nv_pkg::*;
    // Bound on a busy run: all four program times summed, with slack for commit and cleanup
    localparam int BUSY_MAX = ERASE0_CYCLES + WRITE0_CYCLES + ERASE1_CYCLES + WRITE1_CYCLES + 40;
    int   busy_cnt_q;                         // Length of current busy run
    int   busy_cnt_d;                         // Next run length
    logic mapped;                             // Address hits a register
    assign mapped = PADDR inside {OFF_ADDR_LO, OFF_ADDR_HI, OFF_DATA, OFF_CTRL, OFF_STAT};
    // Busy run counter
    always_comb begin
        busy_cnt_d = NV_BUSY ? busy_cnt_q + 1 : 0;
    end
    always_ff @(posedge CORE_CLK) begin
        busy_cnt_q <= SYS_RST ? 0 : busy_cnt_d;
    end
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    AST_READY_LATENCY: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
        else $error("ready late");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
    AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
    AST_DECODE_ERROR: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("bad decode");
    AST_ERROR_READS_ZERO: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read nonzero");
    AST_BYTE_LANE: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h00_0000)
        else $error("upper bits set");
    AST_RESET_IDLE: assert property ($past(SYS_RST) |-> !NV_BUSY && !NV_DONE && !PREADY)
        else $error("not idle after reset");
    AST_DONE_AFTER_RUN: assert property ($rose(NV_DONE) |-> $past(NV_BUSY, 3))
        else $error("done without operation");
    AST_BUSY_BOUND: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("operation too long");
    COV_DONE: cover property ($rose(NV_DONE));
    COV_ERROR: cover property (PREADY && PSLVERR);
    COV_READ: cover property (PREADY && !PWRITE && PADDR == OFF_DATA);
endmodule

// [testbench/nv_ctrl_bench.sv]
// Self-checking bench for the nonvolatile memory controller.
// Assumes nv_pkg, nv_ctrl and nv_ctrl_monitor are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
bind nv_ctrl nv_ctrl_monitor #(.ERASE0_CYCLES(ERASE0_CYCLES), .WRITE0_CYCLES(WRITE0_CYCLES),
    .ERASE1_CYCLES(ERASE1_CYCLES), .WRITE1_CYCLES(WRITE1_CYCLES)) u_mon (.CORE_CLK, .SYS_RST,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .NV_DONE, .NV_BUSY);
module nv_ctrl_bench;
    import nv_pkg::*;
    localparam int E0 = 20, W0 = 15, E1 = 25, W1 = 18;  // Shortened program times
    logic        CORE_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, NV_DONE, NV_BUSY;
    logic [7:0]  PADDR;                       // Bus address
    logic [31:0] PWDATA, PRDATA;              // Bus data
    int          miscompares = 0;             // Mismatch count
    int          cmp_count = 0;               // Comparison count
    logic [16:0] expq[$];                     // Notes: {error, mask, value}
    logic [31:0] seed = 32'h0001_8106;        // Xorshift state
    nv_ctrl #(.ERASE0_CYCLES(E0), .WRITE0_CYCLES(W0), .ERASE1_CYCLES(E1), .WRITE1_CYCLES(W1))
        DUT (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
             .PREADY, .PSLVERR, .NV_DONE, .NV_BUSY);
    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // One APB transfer; a read leaves its expectation in the queue
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [16:0] ex);
        int n;
        n = 0;
        if (!w) expq.push_back(ex);
        @(posedge CORE_CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= {rnd(), rnd(), rnd(), d};
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (!PREADY && n < 20);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            $display("unexpected at %0t: no ready", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 17'h0_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m = 8'hFF,
                      input logic e = 1'b0);
        xfer(1'b0, a, 8'h00, {e, m, v & m});
    endtask
    task automatic setadr(input logic [9:0] a);
        wr(OFF_ADDR_LO, a[7:0]);
        wr(OFF_ADDR_HI, {6'h00, a[9:8]});
    endtask
    // Enable, start on the next access, time the run, check cleanup.
    // Sub clock is taken as stable and interrupts as masked here
    task automatic prog(input logic [7:0] base, input logic [7:0] en, input int cyc);
        int n;
        int lo;
        // Commit takes one cycle in byte mode and sixteen in page mode
        lo = cyc + (base[CB_MODE] ? 18 : 3);
        wr(OFF_CTRL, base | en);
        wr(OFF_CTRL, base | en | (en >> 1));
        @(posedge CORE_CLK);
        `CHK(NV_BUSY, 1'b1)
        n = 1;
        // No register is touched until the run has ended
        while (!NV_DONE && n < 5000) begin
            @(posedge CORE_CLK);
            n++;
        end
        `CHK(n >= lo && n <= lo + 2, 1'b1)
        rd(OFF_CTRL, base);
        rd(OFF_STAT, 8'h01, 8'h01);
        wr(OFF_STAT, 8'h01);
        rd(OFF_STAT, 8'h00, 8'h01);
    endtask
    // Result checker: oldest note against each completed read
    always @(posedge CORE_CLK) begin
        if (PREADY && !PWRITE && expq.size() > 0) begin
            `CHK({PSLVERR, PRDATA[7:0] & expq[0][15:8]}, {expq[0][16], expq[0][7:0]})
            void'(expq.pop_front());
        end
    end
    task automatic print_verdict();
        $display("counts: %0d compares, %0d miscompares", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [5:0] pg;
        logic [7:0] v [2];
        SYS_RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        repeat (3) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        for (int k = 0; k < 5; k++) rd(8'(4 * k), 8'h00);
        rd(8'h14, 8'h00, 8'hFF, 1'b1);
        wr(8'h14, rnd());
        $display("test reset and decode done");
        pg = 6'(rnd());
        for (int k = 0; k < 2; k++) begin
            v[k] = rnd() | 8'h01;
            setadr({pg, k ? 4'hF : 4'hC});
            wr(OFF_DATA, v[k]);
            prog({k[0], 7'h00}, 8'h08, k ? W1 : W0);
            wr(OFF_DATA, ~v[k]);
            wr(OFF_CTRL, 8'h02);
            wr(OFF_CTRL, 8'h03);
            rd(OFF_CTRL, 8'h02);
            rd(OFF_DATA, v[k]);
        end
        $display("test byte write and read done");
        wr(OFF_CTRL, 8'h20);
        rd(OFF_CTRL, 8'h00, 8'h20);
        wr(OFF_CTRL, 8'h04);
        rd(OFF_CTRL, 8'h00, 8'h04);
        wr(OFF_CTRL, 8'h40);
        rd(OFF_STAT, 8'h00, 8'h02);
        wr(OFF_CTRL, 8'h60);
        rd(OFF_CTRL, 8'h00, 8'h20);
        wr(OFF_DATA, 8'h5A);
        wr(OFF_CTRL, 8'h01);
        rd(OFF_DATA, 8'h5A);
        $display("test refused starts done");
        setadr({pg, 4'hD});
        wr(OFF_CTRL, 8'h10);
        repeat (4) wr(OFF_DATA, rnd());
        rd(OFF_ADDR_LO, {pg[3:0], 4'hF});
        prog(8'h90, 8'h40, E1);
        setadr({pg, 4'hC});
        wr(OFF_CTRL, 8'h12);
        for (int k = 0; k < 5; k++) begin
            wr(OFF_CTRL, 8'h13);
            rd(OFF_DATA, k == 0 ? v[0] : 8'h00);
        end
        rd(OFF_ADDR_LO, {pg[3:0], 4'hF});
        rd(OFF_ADDR_HI, {6'h00, pg[5:4]});
        $display("test page erase and read done");
        setadr({pg, 4'hC});
        wr(OFF_DATA, rnd());
        wr(OFF_CTRL, 8'h50);
        wr(OFF_CTRL, 8'h10);
        prog(8'h10, 8'h40, E0);
        setadr({pg, 4'hC});
        wr(OFF_CTRL, 8'h02);
        wr(OFF_CTRL, 8'h03);
        rd(OFF_DATA, v[0]);
        $display("test buffer clear done");
        setadr({pg, 4'hE});
        wr(OFF_CTRL, 8'h10);
        wr(OFF_DATA, v[1]);
        prog(8'h10, 8'h08, W0);
        setadr({pg, 4'hE});
        wr(OFF_CTRL, 8'h12);
        wr(OFF_CTRL, 8'h13);
        rd(OFF_DATA, v[1]);
        wr(OFF_CTRL, 8'h13);
        rd(OFF_DATA, 8'h00);
        setadr({pg, 4'hE});
        prog(8'h00, 8'h40, E0);
        wr(OFF_CTRL, 8'h02);
        wr(OFF_CTRL, 8'h03);
        rd(OFF_DATA, 8'h00);
        $display("test page write and byte erase done");
        print_verdict();
    end
endmodule
